// ===== common/frs_pkg.sv
// constants for the flash row erase/write sequencer
// Function
// - program never erases the row first
// - one commit writes at most 16 words
// - latches row aligned, low bits pick latch
// - latches blank after every program
// - latches blank after erase; partial loads allowed
// - load-only set: unlock only fills one latch
// - load-only clear: fill last latch, program row
// - all latches programmed in one operation
// - key 55h then AAh then write-start
// - broken key starts nothing
// - latch load: two forced no-ops, no stall
// - erase: no-ops, stall, resume after
// - program: no-ops, stall, resume after
// - start bits cleared only by hardware
// - reset during write sets error flag
// - unlock register reads as zero
// - erase stall lasts about 2 ms
package frs_pkg;
  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [4:0] OFF_ADDR_LOW = 5'h00;
  localparam logic [4:0] OFF_ADDR_HIGH = 5'h04;
  localparam logic [4:0] OFF_DATA_LOW = 5'h08;
  localparam logic [4:0] OFF_DATA_HIGH = 5'h0C;
  localparam logic [4:0] OFF_CONTROL = 5'h10;
  localparam logic [4:0] OFF_UNLOCK = 5'h14;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int BIT_READ_START = 0;
  localparam int BIT_WRITE_START = 1;
  localparam int BIT_WRITE_ENABLE = 2;
  localparam int BIT_WRITE_ERROR = 3;
  localparam int BIT_LOAD_ONLY = 4;
  localparam int BIT_ERASE_SELECT = 5;
  localparam int BIT_CONFIG_SELECT = 6;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] ADDR_HIGH_FILL = 8'h80;
  // ----------------------------------------
  // array shape and reset values
  // ----------------------------------------
  localparam int LATCH_COUNT = 16;
  localparam int WORD_BITS = 14;
  localparam int ROW_BITS = 10;
  localparam logic [13:0] BLANK_WORD = 14'h3FFF;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 50;
  localparam int INSTR_NS = 200;
  localparam int NOP_INSTRS = 2;
  localparam int NOP_CYCLES = NOP_INSTRS * INSTR_NS / CLK_NS;
  localparam int ERASE_US = 2000;
  localparam int PROG_US = 2000;
  localparam int ERASE_CYCLES = ERASE_US * 1000 / CLK_NS;
  localparam int PROG_CYCLES = PROG_US * 1000 / CLK_NS;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_NOP = 3'b010,
    ST_BUSY = 3'b100
  } frs_state_type;
  typedef enum logic [2:0] {
    OP_LOAD = 3'b001,
    OP_ERASE = 3'b010,
    OP_PROG = 3'b100
  } frs_op_type;
endpackage

// ===== hdl/frs_sequencer.sv
// flash row erase/write sequencer with avalon-mm register slave
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module frs_sequencer #(
  parameter int ERASE_CYC = frs_pkg::ERASE_CYCLES,
  parameter int PROG_CYC = frs_pkg::PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rst_power_on,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic cpu_nop_force,
  output logic cpu_stall,
  output logic flash_erase,
  output logic flash_prog,
  output logic [9:0] flash_row,
  output logic [223:0] flash_row_data
);
  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [7:0] flash_addr_low;
  logic [6:0] flash_addr_high;
  logic [7:0] flash_data_low;
  logic [5:0] flash_data_high;
  logic read_start;
  logic write_start;
  logic write_enable_bit;
  logic write_error_flag;
  logic load_latches_only;
  logic erase_select;
  logic config_space_select;
  logic [1:0] key_stage;
  logic [13:0] latch [16];
  frs_pkg::frs_state_type state;
  frs_pkg::frs_state_type next_state;
  frs_pkg::frs_op_type op;
  logic [15:0] cnt;
  logic [1:0] next_key;

  function automatic logic [15:0] last_of(input int n);
    last_of = 16'(n - 1);
  endfunction

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire acc_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire rd_take = avs_read && avs_waitrequest;
  wire [7:0] wd = avs_writedata[7:0];
  wire wr_alo = acc_wr && avs_address == frs_pkg::OFF_ADDR_LOW;
  wire wr_ahi = acc_wr && avs_address == frs_pkg::OFF_ADDR_HIGH;
  wire wr_dlo = acc_wr && avs_address == frs_pkg::OFF_DATA_LOW;
  wire wr_dhi = acc_wr && avs_address == frs_pkg::OFF_DATA_HIGH;
  wire wr_ctl = acc_wr && avs_address == frs_pkg::OFF_CONTROL;
  wire wr_key = acc_wr && avs_address == frs_pkg::OFF_UNLOCK;
  wire [7:0] ctl_rd = {1'b0, config_space_select, erase_select, load_latches_only,
    write_error_flag, write_enable_bit, write_start, read_start};
  wire [14:0] full_addr = {flash_addr_high, flash_addr_low};
  wire [3:0] latch_idx = full_addr[3:0];
  wire [9:0] row_sel = full_addr[13:4];
  wire [7:0] rd_mux =
    avs_address == frs_pkg::OFF_ADDR_LOW ? flash_addr_low :
    avs_address == frs_pkg::OFF_ADDR_HIGH ? (frs_pkg::ADDR_HIGH_FILL | {1'b0, flash_addr_high}) :
    avs_address == frs_pkg::OFF_DATA_LOW ? flash_data_low :
    avs_address == frs_pkg::OFF_DATA_HIGH ? {2'b00, flash_data_high} :
    avs_address == frs_pkg::OFF_CONTROL ? ctl_rd : 8'h00;

  // ----------------------------------------
  // unlock and start
  // ----------------------------------------
  // any other write breaks the key
  always_comb begin
    next_key = key_stage;
    if (acc_wr) begin
      if (wr_key && wd == frs_pkg::KEY_FIRST) begin
        next_key = 2'h1;
      end else if (wr_key && wd == frs_pkg::KEY_SECOND && key_stage == 2'h1) begin
        next_key = 2'h2;
      end else begin
        next_key = 2'h0;
      end
    end
  end
  wire start_req = wr_ctl && wd[frs_pkg::BIT_WRITE_START];
  wire go = start_req && key_stage == 2'h2 && write_enable_bit && !config_space_select
    && state == frs_pkg::ST_IDLE;
  wire [2:0] go_op = erase_select ? frs_pkg::OP_ERASE :
    load_latches_only ? frs_pkg::OP_LOAD : frs_pkg::OP_PROG;
  wire load_now = go && !erase_select;
  wire nop_end = state == frs_pkg::ST_NOP && cnt == last_of(frs_pkg::NOP_CYCLES);
  wire busy_lim = op == frs_pkg::OP_ERASE ? cnt == last_of(ERASE_CYC) : cnt == last_of(PROG_CYC);
  wire busy_end = state == frs_pkg::ST_BUSY && busy_lim;

  // ----------------------------------------
  // sequence control
  // ----------------------------------------
  always_comb begin
    case (state)
      frs_pkg::ST_IDLE: next_state = go ? frs_pkg::ST_NOP : frs_pkg::ST_IDLE;
      frs_pkg::ST_NOP: begin
        if (!nop_end) begin
          next_state = frs_pkg::ST_NOP;
        end else if (op == frs_pkg::OP_LOAD) begin
          next_state = frs_pkg::ST_IDLE;
        end else begin
          next_state = frs_pkg::ST_BUSY;
        end
      end
      frs_pkg::ST_BUSY: next_state = busy_end ? frs_pkg::ST_IDLE : frs_pkg::ST_BUSY;
      default: next_state = frs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= frs_pkg::ST_IDLE;
      op <= frs_pkg::OP_LOAD;
      cnt <= 16'h0000;
      key_stage <= 2'h0;
    end else begin
      state <= next_state;
      key_stage <= next_key;
      cnt <= (state != next_state) ? 16'h0000 : cnt + 16'h0001;
      if (go) begin
        op <= frs_pkg::frs_op_type'(go_op);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_nop_force <= 1'b0;
      cpu_stall <= 1'b0;
    end else begin
      cpu_nop_force <= next_state == frs_pkg::ST_NOP;
      cpu_stall <= next_state == frs_pkg::ST_BUSY;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_addr_low <= 8'h00;
      flash_addr_high <= 7'h00;
      flash_data_low <= 8'h00;
      flash_data_high <= 6'h00;
      write_enable_bit <= 1'b0;
      load_latches_only <= 1'b0;
      erase_select <= 1'b0;
      config_space_select <= 1'b0;
    end else begin
      if (wr_alo) begin
        flash_addr_low <= wd;
      end
      if (wr_ahi) begin
        flash_addr_high <= wd[6:0];
      end
      if (wr_dlo) begin
        flash_data_low <= wd;
      end
      if (wr_dhi) begin
        flash_data_high <= wd[5:0];
      end
      if (wr_ctl) begin
        write_enable_bit <= wd[frs_pkg::BIT_WRITE_ENABLE];
        load_latches_only <= wd[frs_pkg::BIT_LOAD_ONLY];
        erase_select <= wd[frs_pkg::BIT_ERASE_SELECT];
        config_space_select <= wd[frs_pkg::BIT_CONFIG_SELECT];
      end
    end
  end

  // start bits: software sets, hardware clears
  always_ff @(posedge clk) begin
    if (rst) begin
      read_start <= 1'b0;
      write_start <= 1'b0;
    end else begin
      read_start <= wr_ctl && wd[frs_pkg::BIT_READ_START];
      if (go) begin
        write_start <= 1'b1;
      end else if (next_state == frs_pkg::ST_IDLE) begin
        write_start <= 1'b0;
      end
    end
  end

  // survives plain reset; power-on clears it
  always_ff @(posedge clk) begin
    if (rst_power_on) begin
      write_error_flag <= 1'b0;
    end else if (rst && state != frs_pkg::ST_IDLE && op != frs_pkg::OP_LOAD) begin
      write_error_flag <= 1'b1;
    end else if (!rst && wr_ctl) begin
      write_error_flag <= wd[frs_pkg::BIT_WRITE_ERROR];
    end
  end

  // ----------------------------------------
  // write latches and flash strobes
  // ----------------------------------------
  always_ff @(posedge clk) begin
    // blank at reset and at the end of every erase or program
    if (rst || busy_end) begin
      for (int i = 0; i < frs_pkg::LATCH_COUNT; i++) begin
        latch[i] <= frs_pkg::BLANK_WORD;
      end
    end else if (load_now) begin
      latch[latch_idx] <= {flash_data_high, flash_data_low};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flash_erase <= 1'b0;
      flash_prog <= 1'b0;
      flash_row <= 10'h000;
      flash_row_data <= '1;
    end else begin
      flash_erase <= busy_end && op == frs_pkg::OP_ERASE;
      flash_prog <= busy_end && op == frs_pkg::OP_PROG;
      if (go) begin
        flash_row <= row_sel;
      end
      if (busy_end && op == frs_pkg::OP_PROG) begin
        for (int i = 0; i < frs_pkg::LATCH_COUNT; i++) begin
          flash_row_data[i*14 +: 14] <= latch[i];
        end
      end
    end
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      // one wait state: low for one cycle per request
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (rd_take) begin
        avs_readdata <= {24'h000000, rd_mux};
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // every latch must be blank, not just a sample of them
  logic all_blank;
  always_comb begin
    all_blank = 1'b1;
    for (int i = 0; i < frs_pkg::LATCH_COUNT; i++) begin
      if (latch[i] != frs_pkg::BLANK_WORD) begin
        all_blank = 1'b0;
      end
    end
  end
  wire [13:0] cur_latch = latch[latch_idx];

  property p_no_auto_erase;
    @(posedge clk) disable iff (rst) flash_prog |-> !flash_erase && $past(op) == frs_pkg::OP_PROG;
  endproperty
  a_no_auto_erase: assert property (p_no_auto_erase) else $error("erase during program");

  property p_prog_blank;
    @(posedge clk) disable iff (rst) flash_prog |-> all_blank && !cpu_stall;
  endproperty
  a_prog_blank: assert property (p_prog_blank) else $error("latches not blank after program");

  property p_erase_blank;
    @(posedge clk) disable iff (rst) flash_erase |-> all_blank;
  endproperty
  a_erase_blank: assert property (p_erase_blank) else $error("latches not blank after erase");

  property p_load_only;
    @(posedge clk) disable iff (rst) (go && go_op == frs_pkg::OP_LOAD)
      |=> cpu_nop_force [*8] ##1 (!cpu_nop_force && !cpu_stall && !write_start);
  endproperty
  a_load_only: assert property (p_load_only) else $error("latch load did not end after no-ops");

  property p_load_data;
    @(posedge clk) disable iff (rst) load_now
      |=> cur_latch == $past({flash_data_high, flash_data_low});
  endproperty
  a_load_data: assert property (p_load_data) else $error("latch not loaded");

  property p_stall_after_nops;
    @(posedge clk) disable iff (rst) $rose(cpu_stall) |-> $past(cpu_nop_force) && op != frs_pkg::OP_LOAD;
  endproperty
  a_stall_after_nops: assert property (p_stall_after_nops) else $error("stall without no-ops");

  property p_key_order;
    @(posedge clk) disable iff (rst) key_stage == 2'h2 |-> $past(key_stage) inside {2'h1, 2'h2};
  endproperty
  a_key_order: assert property (p_key_order) else $error("key out of order");

  property p_no_key_ignored;
    @(posedge clk) disable iff (rst) (start_req && key_stage != 2'h2)
      |=> state == frs_pkg::ST_IDLE && $stable(cur_latch);
  endproperty
  a_no_key_ignored: assert property (p_no_key_ignored) else $error("start accepted without key");

  property p_read_start_clear;
    @(posedge clk) disable iff (rst) read_start |=> !read_start;
  endproperty
  a_read_start_clear: assert property (p_read_start_clear) else $error("read start stuck");

  property p_unlock_reads_zero;
    @(posedge clk) disable iff (rst) (rd_take && avs_address == frs_pkg::OFF_UNLOCK)
      |=> avs_readdata == 32'h00000000 && !avs_waitrequest;
  endproperty
  a_unlock_reads_zero: assert property (p_unlock_reads_zero) else $error("unlock read not zero");

  property p_reset_error;
    @(posedge clk) disable iff (rst_power_on) (rst && state == frs_pkg::ST_BUSY) |=> write_error_flag;
  endproperty
  a_reset_error: assert property (p_reset_error) else $error("error flag not set");

  property p_resume_after_stall;
    @(posedge clk) disable iff (rst) (flash_erase || flash_prog) |-> $past(cpu_stall) && !cpu_stall && !cpu_nop_force;
  endproperty
  a_resume_after_stall: assert property (p_resume_after_stall) else $error("stall did not end with operation");

  c_erase: cover property (@(posedge clk) disable iff (rst) flash_erase);
  c_prog: cover property (@(posedge clk) disable iff (rst) flash_prog);
  c_load: cover property (@(posedge clk) disable iff (rst) go && go_op == frs_pkg::OP_LOAD);
  c_broken_key: cover property (@(posedge clk) disable iff (rst) start_req && key_stage != 2'h2);
  c_config_refused: cover property (@(posedge clk) disable iff (rst) start_req && config_space_select);
endmodule

// ===== dv/frs_flash_model.sv
// flash array model on the far side of the sequencer
`timescale 1ns/100ps
module frs_flash_model (
  input wire logic clk,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic [9:0] flash_row,
  input wire logic [223:0] flash_row_data,
  input wire logic [9:0] peek_row,
  output logic [223:0] peek_data,
  output int erase_n,
  output int prog_n
);
  logic [223:0] mem [1024];
  assign peek_data = mem[peek_row];
  initial begin
    erase_n = 0;
    prog_n = 0;
    foreach (mem[i]) mem[i] = '1;
  end
  always @(posedge clk) begin
    if (flash_erase === 1'h1) begin
      mem[flash_row] <= '1;
      erase_n <= erase_n + 1;
    end
    // cells only clear, whole row at once
    if (flash_prog === 1'h1) begin
      mem[flash_row] <= mem[flash_row] & flash_row_data;
      prog_n <= prog_n + 1;
    end
  end
endmodule

// ===== dv/test_frs_sequencer.sv
// self-checking bench for the flash row sequencer
`timescale 1ns/100ps
module test_frs_sequencer;
  localparam int PC = 20;
  localparam logic [4:0] CT = frs_pkg::OFF_CONTROL;
  localparam logic [4:0] UN = frs_pkg::OFF_UNLOCK;
  localparam logic [7:0] WS = 8'(1 << frs_pkg::BIT_WRITE_START);
  localparam logic [7:0] WE = 8'(1 << frs_pkg::BIT_WRITE_ENABLE);
  localparam logic [7:0] LO = 8'(1 << frs_pkg::BIT_LOAD_ONLY);
  localparam logic [7:0] ES = 8'(1 << frs_pkg::BIT_ERASE_SELECT);
  localparam logic [7:0] ER = 8'(1 << frs_pkg::BIT_WRITE_ERROR);
  localparam logic [7:0] CS = 8'(1 << frs_pkg::BIT_CONFIG_SELECT);
  localparam logic [7:0] RS = 8'(1 << frs_pkg::BIT_READ_START);
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic rst_power_on = 1'h1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rv;
  logic avs_waitrequest, cpu_nop_force, cpu_stall, flash_erase, flash_prog;
  logic [9:0] flash_row;
  logic [9:0] peek_row = 10'h000;
  logic [223:0] flash_row_data, peek_data, ev;
  int erase_n, prog_n;
  int nop_n = 0;
  int stall_n = 0;
  int cyc = 0;
  int n_mismatch = 0;
  int check_count = 0;
  frs_sequencer #(.ERASE_CYC(PC), .PROG_CYC(PC)) dut (.clk(clk), .rst(rst), .rst_power_on(rst_power_on),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_nop_force(cpu_nop_force), .cpu_stall(cpu_stall), .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_row(flash_row), .flash_row_data(flash_row_data));
  frs_flash_model fm (.clk(clk), .flash_erase(flash_erase), .flash_prog(flash_prog), .flash_row(flash_row),
    .flash_row_data(flash_row_data), .peek_row(peek_row), .peek_data(peek_data), .erase_n(erase_n),
    .prog_n(prog_n));
  initial begin
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // phase counters and hang limit
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cpu_nop_force === 1'h1) nop_n <= nop_n + 1;
    if (cpu_stall === 1'h1) stall_n <= stall_n + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [223:0] exp, input logic [223:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // request held until waitrequest sampled low
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'h0);
    rv = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] exp);
    xfer(1'h0, a, 8'h00);
    check(nm, 224'(exp), 224'(rv));
  endtask
  task automatic put(input logic [13:0] a, input logic [13:0] d);
    wr(frs_pkg::OFF_ADDR_HIGH, {2'h0, a[13:8]});
    wr(frs_pkg::OFF_ADDR_LOW, a[7:0]);
    wr(frs_pkg::OFF_DATA_LOW, d[7:0]);
    wr(frs_pkg::OFF_DATA_HIGH, {2'h0, d[13:8]});
  endtask
  // control first, then key, then start with same bits
  task automatic go(input logic [7:0] c);
    wr(CT, c);
    wr(UN, frs_pkg::KEY_FIRST);
    wr(UN, frs_pkg::KEY_SECOND);
    nop_n = 0;
    stall_n = 0;
    wr(CT, c | WS);
  endtask
  task automatic idle();
    for (int i = 0; i < 100; i++) begin
      xfer(1'h0, CT, 8'h00);
      if (rv[1] === 1'h0) break;
    end
  endtask
  task automatic peek(input string nm, input logic [9:0] r, input logic [223:0] exp);
    peek_row <= r;
    @(posedge clk);
    @(posedge clk);
    check(nm, exp, peek_data);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rst_power_on <= 1'h0;
    rchk("addr_high", frs_pkg::OFF_ADDR_HIGH, frs_pkg::ADDR_HIGH_FILL);
    rchk("control", CT, 8'h00);
    wr(CT, RS);
    rchk("read start", CT, 8'h00);
    wr(UN, 8'h5A);
    rchk("unlock", UN, 8'h00);
    rchk("unmapped", 5'h18, 8'h00);
    // refused starts: no enable, wrong order, broken key, config space
    put(14'h0050, 14'h1234);
    wr(CT, LO);
    wr(UN, frs_pkg::KEY_FIRST);
    wr(UN, frs_pkg::KEY_SECOND);
    wr(CT, LO | WS);
    rchk("no enable", CT, LO);
    wr(CT, WE | LO);
    wr(UN, frs_pkg::KEY_SECOND);
    wr(UN, frs_pkg::KEY_FIRST);
    wr(CT, WE | LO | WS);
    rchk("key order", CT, WE | LO);
    wr(UN, frs_pkg::KEY_FIRST);
    wr(frs_pkg::OFF_DATA_LOW, 8'h34);
    wr(UN, frs_pkg::KEY_SECOND);
    wr(CT, WE | LO | WS);
    rchk("broken key", CT, WE | LO);
    wr(CT, WE | LO | CS);
    wr(UN, frs_pkg::KEY_FIRST);
    wr(UN, frs_pkg::KEY_SECOND);
    wr(CT, WE | LO | CS | WS);
    rchk("config space", CT, WE | LO | CS);
    check("refused nop", 224'(0), 224'(nop_n));
    // full row: 15 loads then commit
    for (int i = 0; i < 16; i++) begin
      put(14'h0050 + 14'(i), 14'h0100 + 14'(i));
      go(i < 15 ? WE | LO : WE);
      if (i == 15) begin
        wr(CT, WE);
        rchk("start held", CT, WE | WS);
      end
      idle();
      check("nop", 224'(frs_pkg::NOP_CYCLES), 224'(nop_n));
      check("stall", 224'(i < 15 ? 0 : PC), 224'(stall_n));
      check("prog count", 224'(i < 15 ? 0 : 1), 224'(prog_n));
      ev[14*i +: 14] = 14'h0100 + 14'(i);
    end
    check("start cleared", 224'(WE), 224'(rv));
    peek("row5", 10'h005, ev);
    // single word after a commit: others blank
    op_single(14'h0067, 14'h2A55);
    ev = '1;
    ev[14*7 +: 14] = 14'h2A55;
    peek("row6", 10'h006, ev);
    check("no erase", 224'(0), 224'(erase_n));
    // erase with a latch preloaded
    put(14'h0052, 14'h0ABC);
    go(WE | LO);
    idle();
    put(14'h005A, 14'h0000);
    go(WE | ES);
    idle();
    check("erase nop", 224'(frs_pkg::NOP_CYCLES), 224'(nop_n));
    check("erase stall", 224'(PC), 224'(stall_n));
    check("erase count", 224'(1), 224'(erase_n));
    peek("row5 erased", 10'h005, '1);
    op_single(14'h0051, 14'h0777);
    ev = '1;
    ev[14*1 +: 14] = 14'h0777;
    peek("row5 after erase", 10'h005, ev);
    // reset during erase stall
    put(14'h005A, 14'h0000);
    go(WE | ES);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (cpu_stall === 1'h1) break;
    end
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rchk("error flag", CT, ER);
    check("aborted erase", 224'(1), 224'(erase_n));
    rst <= 1'h1;
    rst_power_on <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rst_power_on <= 1'h0;
    rchk("power on clear", CT, 8'h00);
    wrap_up();
  end
  task automatic op_single(input logic [13:0] a, input logic [13:0] d);
    put(a, d);
    go(WE);
    idle();
  endtask
endmodule
